// file: rtl/dopwm_top.v
// dual output pwm with dead time, modulation compare and steering
//
// Overview of operation
// - outputs on only while dead-time and modulation compares are both low
// - inverted combined compare clocks the steering flip-flop in push-pull
// - parallel mode masks steering; both outputs carry every pulse
// - linear sawtooth ramp restarts at minimum on reaching full scale
// - output rate is ramp rate in parallel, half in push-pull
// - ramp period programmable across 1 kHz to 300 kHz
// - both outputs inhibited while dead-time setting exceeds ramp
// - fixed offset guarantees three percent minimum off time
// - off time rises linearly to full period with dead-time setting
// - on-time falls from 97 percent to zero as control level rises
// - external sawtooth may replace the internal ramp for synchronising
// - push-pull never gives two pulses in a row on one output
// - steering toggles on compare rise, only after a pulse that period
`timescale 1ns/10ps
`include "dopwm_regs.vh"

module dopwm_top
#(
  parameter RAMP_W     = `DOPWM_RAMP_W,
  parameter SET_W      = `DOPWM_SET_W,
  parameter PERIOD_MIN = `DOPWM_PERIOD_MIN,
  parameter PERIOD_MAX = `DOPWM_PERIOD_MAX,
  parameter BLANK_MIN  = `DOPWM_BLANK_MIN_CYC
)
(
  input  wire              I_CLOCK,
  input  wire              I_ARST_N,
  input  wire [RAMP_W-1:0] i_PERIOD,
  input  wire [SET_W-1:0]  i_DEADTIME,
  input  wire [SET_W-1:0]  i_CONTROL,
  input  wire              i_PUSH_PULL,
  input  wire              i_EXT_RAMP_SEL,
  input  wire [RAMP_W-1:0] i_EXT_RAMP,
  output wire              o_DRIVE_OUTPUT_A,
  output wire              o_DRIVE_OUTPUT_B,
  output wire [RAMP_W-1:0] o_RAMP,
  output wire              o_PERIOD_START,
  output wire              o_STEER,
  output wire              o_INHIBIT,
  output wire              o_BLANK_SHORT,
  output wire [RAMP_W-1:0] o_ON_CYCLES
);

  localparam PROD_W = RAMP_W + SET_W;
  localparam PCT_W  = RAMP_W + `DOPWM_PCT_PAD_W;
  localparam NOUT   = `DOPWM_NUM_OUT;
  localparam NCMP   = `DOPWM_NUM_CMP;
  localparam SETS_W = NCMP * SET_W;

  // percent constants at product width, so nothing is cut silently
  localparam [PCT_W-1:0] OFF_PCT  = `DOPWM_MIN_OFF_PCT;
  localparam [PCT_W-1:0] PCT_FULL = `DOPWM_PCT_FULL;
  localparam [PCT_W-1:0] PCT_RND  = `DOPWM_PCT_FULL - 1;

  wire [RAMP_W-1:0] ramp;
  wire              wrap;
  reg  [RAMP_W-1:0] period_c;
  wire [PCT_W-1:0]  off_prod;
  wire [PCT_W-1:0]  off_div;
  wire [RAMP_W-1:0] min_off;
  wire [RAMP_W-1:0] span;
  wire [SETS_W-1:0] settings;
  wire [NCMP-1:0]   cmp;
  wire              dt_cmp;
  wire              pwm_cmp;
  wire              inhibit;
  wire              enable;
  wire [NOUT-1:0]   drive;

  reg               inhibit_q;
  reg               steer_q;
  reg               steer_d;
  reg               seen_q;
  reg               seen_d;
  reg               wrap_q;
  reg  [RAMP_W-1:0] blank_q;
  reg  [RAMP_W-1:0] blank_d;
  reg               short_q;
  reg               short_d;
  reg  [RAMP_W-1:0] on_q;
  reg  [RAMP_W-1:0] on_d;
  reg  [RAMP_W-1:0] on_last_q;
  reg  [RAMP_W-1:0] on_last_d;

  // clamp period to supported range
  // out-of-range periods are clamped rather than refused
  always @*
  begin
    if (i_PERIOD < PERIOD_MIN[RAMP_W-1:0])
    begin
      period_c = PERIOD_MIN[RAMP_W-1:0];
    end
    else if (i_PERIOD > PERIOD_MAX[RAMP_W-1:0])
    begin
      period_c = PERIOD_MAX[RAMP_W-1:0];
    end
    else
    begin
      period_c = i_PERIOD;
    end
  end

  dopwm_ramp
  #(
    .RAMP_W     (RAMP_W)
  )
  u_ramp
  (
    .i_clk      (I_CLOCK),
    .i_arst_n   (I_ARST_N),
    .i_period   (period_c),
    .i_ext_sel  (i_EXT_RAMP_SEL),
    .i_ext_ramp (i_EXT_RAMP),
    .o_ramp     (ramp),
    .o_wrap     (wrap)
  );

  // built-in offset, three percent of period rounded up
  assign off_prod = {{(PCT_W-RAMP_W){1'b0}}, period_c} * OFF_PCT + PCT_RND;
  assign off_div  = off_prod / PCT_FULL;
  // quotient is below the period, so the low bits hold it all
  assign min_off  = off_div[RAMP_W-1:0];
  assign span     = period_c - min_off;

  // dead time first, then control level, through one scaling path
  assign settings = {i_CONTROL, i_DEADTIME};

  // thresholds span min off to the full period
  genvar k;
  generate
    for (k = 0; k < NCMP; k = k + 1)
    begin : g_cmp
      wire [SET_W-1:0]  level;
      wire [PROD_W-1:0] prod;
      wire [PROD_W-1:0] scaled;
      wire [RAMP_W:0]   th;

      assign level  = settings[k*SET_W +: SET_W];
      assign prod   = span * level;
      assign scaled = prod / `DOPWM_SET_FULL;
      assign th     = {1'b0, min_off} + scaled[RAMP_W:0];

      // high while threshold is above the ramp
      assign cmp[k] = (th > {1'b0, ramp});
    end
  endgenerate

  assign dt_cmp  = cmp[0];
  assign pwm_cmp = cmp[1];

  // combined compare by OR; outputs only while low
  assign inhibit = dt_cmp | pwm_cmp;
  assign enable  = ~inhibit;

  // toggle on compare rise if a pulse was seen
  // steering runs in both modes, so push-pull resumes in step
  always @*
  begin
    steer_d = steer_q;
    seen_d  = seen_q;
    if (inhibit && !inhibit_q)
    begin
      // inverted result clocks the steering flop
      if (seen_q)
      begin
        steer_d = ~steer_q;
      end
      seen_d = 1'b0;
    end
    if (enable)
    begin
      seen_d = 1'b1;
    end
  end

  // mode acts straight on the output gating
  genvar ch;
  generate
    for (ch = 0; ch < NOUT; ch = ch + 1)
    begin : g_out
      reg  out_q;
      reg  out_d;
      wire turn;

      // channel a owns steer low, channel b owns steer high
      assign turn = (ch == 0) ? ~steer_q : steer_q;

      always @*
      begin
        if (i_PUSH_PULL)
        begin
          // alternate outputs; each at half the ramp rate
          out_d = enable & turn;
        end
        else
        begin
          // steering masked; both at ramp rate
          out_d = enable;
        end
      end

      always @(posedge I_CLOCK or negedge I_ARST_N)
      begin
        if (!I_ARST_N)
        begin
          out_q <= `DOPWM_OUT_OFF;
        end
        else
        begin
          out_q <= out_d;
        end
      end

      assign drive[ch] = out_q;
    end
  endgenerate

  // blanking length check, so a too-short dead time is visible
  // counter saturates so a stuck inhibit never wraps back to short
  always @*
  begin
    blank_d = blank_q;
    short_d = short_q;
    if (inhibit)
    begin
      if (blank_q != {RAMP_W{1'b1}})
      begin
        blank_d = blank_q + {{(RAMP_W-1){1'b0}}, 1'b1};
      end
    end
    else
    begin
      blank_d = {RAMP_W{1'b0}};
    end
    // blanking shorter than the toggle minimum
    if (enable && inhibit_q)
    begin
      short_d = (blank_q < BLANK_MIN[RAMP_W-1:0]);
    end
  end

  // on-time of the last complete period
  // the restart cycle counts as off; wrap wins over enable
  always @*
  begin
    on_d      = on_q;
    on_last_d = on_last_q;
    if (wrap)
    begin
      on_last_d = on_q;
      on_d      = {RAMP_W{1'b0}};
    end
    else if (enable)
    begin
      on_d = on_q + {{(RAMP_W-1){1'b0}}, 1'b1};
    end
  end

  // reset state: outputs off, steering preset
  always @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      // inhibit starts high so no false steering edge follows reset
      inhibit_q <= 1'b1;
      steer_q   <= `DOPWM_STEER_RST;
      seen_q    <= 1'b0;
      wrap_q    <= 1'b0;
      blank_q   <= {RAMP_W{1'b0}};
      short_q   <= 1'b0;
      on_q      <= {RAMP_W{1'b0}};
      on_last_q <= {RAMP_W{1'b0}};
    end
    else
    begin
      inhibit_q <= inhibit;
      steer_q   <= steer_d;
      seen_q    <= seen_d;
      wrap_q    <= wrap;
      blank_q   <= blank_d;
      short_q   <= short_d;
      on_q      <= on_d;
      on_last_q <= on_last_d;
    end
  end

  assign o_DRIVE_OUTPUT_A = drive[0];
  assign o_DRIVE_OUTPUT_B = drive[1];
  assign o_RAMP           = ramp;
  assign o_PERIOD_START   = wrap_q;
  assign o_STEER          = steer_q;
  assign o_INHIBIT        = inhibit_q;
  assign o_BLANK_SHORT    = short_q;
  assign o_ON_CYCLES      = on_last_q;

endmodule // dopwm_top

// file: rtl/dopwm_regs.vh
// constants for the dual output pwm steering block
`ifndef DOPWM_REGS_VH
`define DOPWM_REGS_VH

// clock and ramp frequency range
`define DOPWM_CLK_HZ        40000000
`define DOPWM_F_MIN_HZ      1000
`define DOPWM_F_MAX_HZ      300000
// least period rounds up so the top frequency is never exceeded
`define DOPWM_PERIOD_MIN    ((`DOPWM_CLK_HZ + `DOPWM_F_MAX_HZ - 1) / `DOPWM_F_MAX_HZ)
`define DOPWM_PERIOD_MAX    (`DOPWM_CLK_HZ / `DOPWM_F_MIN_HZ)

// built-in minimum off time, percent of the period
`define DOPWM_MIN_OFF_PCT   3
`define DOPWM_PCT_FULL      100
// headroom bits for the percent product of the period
`define DOPWM_PCT_PAD_W     7

// blanking needed for a clean steering toggle
`define DOPWM_CLK_PERIOD_NS 25
`define DOPWM_BLANK_MIN_NS  200
`define DOPWM_BLANK_MIN_CYC ((`DOPWM_BLANK_MIN_NS + `DOPWM_CLK_PERIOD_NS - 1) / `DOPWM_CLK_PERIOD_NS)

// widths and full-scale codes of the setting inputs
`define DOPWM_RAMP_W        16
`define DOPWM_SET_W         8
`define DOPWM_SET_FULL      8'hFF
`define DOPWM_CNT_W         16
// drive outputs and compare paths
`define DOPWM_NUM_OUT       2
`define DOPWM_NUM_CMP       2

// reset values
`define DOPWM_RAMP_RST      16'h0000
`define DOPWM_STEER_RST     1'b0
`define DOPWM_OUT_OFF       1'b0

`endif

// file: rtl/dopwm_ramp.v
// sawtooth ramp counter with terminal count and external ramp input
`timescale 1ns/10ps
`include "dopwm_regs.vh"

module dopwm_ramp
#(
  parameter RAMP_W = `DOPWM_RAMP_W
)
(
  input  wire              i_clk,
  input  wire              i_arst_n,
  input  wire [RAMP_W-1:0] i_period,
  input  wire              i_ext_sel,
  input  wire [RAMP_W-1:0] i_ext_ramp,
  output wire [RAMP_W-1:0] o_ramp,
  output wire              o_wrap
);

  reg  [RAMP_W-1:0] cnt_q;
  reg  [RAMP_W-1:0] cnt_d;
  reg  [RAMP_W-1:0] ext_q;
  reg               wrap_q;
  reg               wrap_d;
  wire [RAMP_W-1:0] term;
  wire [RAMP_W-1:0] one;

  assign one  = {{(RAMP_W-1){1'b0}}, 1'b1};
  assign term = i_period - one;

  always @*
  begin
    cnt_d  = cnt_q + one;
    wrap_d = 1'b0;
    if (i_ext_sel)
    begin
      // external sawtooth: a fall marks the start of a new period
      cnt_d  = i_ext_ramp;
      wrap_d = (i_ext_ramp < ext_q);
    end
    else if (cnt_q >= term)
    begin
      cnt_d  = `DOPWM_RAMP_RST;
      wrap_d = 1'b1;
    end
  end

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_q  <= `DOPWM_RAMP_RST;
      ext_q  <= `DOPWM_RAMP_RST;
      wrap_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      ext_q  <= i_ext_ramp;
      wrap_q <= wrap_d;
    end
  end

  assign o_ramp = cnt_q;
  assign o_wrap = wrap_q;

endmodule // dopwm_ramp

// file: test/dopwm_top_asserts.sv
// port assertions for the dual output pwm top
`timescale 1ns/10ps
module dopwm_top_asserts
(
  input wire        I_CLOCK,
  input wire        I_ARST_N,
  input wire [15:0] i_PERIOD,
  input wire [7:0]  i_DEADTIME,
  input wire        i_PUSH_PULL,
  input wire        i_EXT_RAMP_SEL,
  input wire        o_DRIVE_OUTPUT_A,
  input wire        o_DRIVE_OUTPUT_B,
  input wire [15:0] o_RAMP,
  input wire        o_STEER,
  input wire        o_INHIBIT
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  property p_gate;
    o_DRIVE_OUTPUT_A || o_DRIVE_OUTPUT_B |-> !o_INHIBIT; endproperty
  a_gate: assert property (p_gate) else $error("drive while inhibited");
  property p_par; !i_PUSH_PULL && $past(!i_PUSH_PULL)
    |-> o_DRIVE_OUTPUT_A == o_DRIVE_OUTPUT_B; endproperty
  a_par: assert property (p_par) else $error("parallel outputs differ");
  property p_excl; $past(i_PUSH_PULL)
    |-> !(o_DRIVE_OUTPUT_A && o_DRIVE_OUTPUT_B); endproperty
  a_excl: assert property (p_excl) else $error("both outputs on");
  property p_side; $past(i_PUSH_PULL) |-> !(o_DRIVE_OUTPUT_A && o_STEER)
    && !(o_DRIVE_OUTPUT_B && !o_STEER); endproperty
  a_side: assert property (p_side) else $error("wrong output steered");
  property p_step; !i_EXT_RAMP_SEL && o_RAMP < i_PERIOD - 16'h0001 ##1
    !i_EXT_RAMP_SEL |-> o_RAMP == $past(o_RAMP) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("ramp step wrong");
  property p_wrap; !i_EXT_RAMP_SEL && o_RAMP == i_PERIOD - 16'h0001
    |=> o_RAMP == 16'h0000; endproperty
  a_wrap: assert property (p_wrap) else $error("ramp did not restart");
  property p_steer; $past(i_PUSH_PULL) && $changed(o_STEER)
    |-> o_INHIBIT && $past(!o_INHIBIT); endproperty
  a_steer: assert property (p_steer) else $error("steer moved early");
  property p_full; $past(i_DEADTIME) == 8'hFF
    |-> !o_DRIVE_OUTPUT_A && !o_DRIVE_OUTPUT_B; endproperty
  a_full: assert property (p_full) else $error("pulse at full dead time");
endmodule // dopwm_top_asserts

bind dopwm_top dopwm_top_asserts dopwm_top_asserts_inst
(
  .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .i_PERIOD(i_PERIOD),
  .i_DEADTIME(i_DEADTIME), .i_PUSH_PULL(i_PUSH_PULL),
  .i_EXT_RAMP_SEL(i_EXT_RAMP_SEL), .o_DRIVE_OUTPUT_A(o_DRIVE_OUTPUT_A),
  .o_DRIVE_OUTPUT_B(o_DRIVE_OUTPUT_B), .o_RAMP(o_RAMP), .o_STEER(o_STEER),
  .o_INHIBIT(o_INHIBIT)
);

// file: test/dopwm_gate_drv.sv
// gate driver pair model counting drive pulses
`timescale 1ns/10ps
module dopwm_gate_drv
(
  input  wire        i_clk,
  input  wire        i_arst_n,
  input  wire        i_drv_a,
  input  wire        i_drv_b,
  output reg  [15:0] o_pulses_a,
  output reg  [15:0] o_pulses_b
);
  reg a_q;
  reg b_q;
  // counts restart with the controller reset
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      {a_q, b_q} <= 2'h0;
      o_pulses_a <= 16'h0000;
      o_pulses_b <= 16'h0000;
    end
    else
    begin
      {a_q, b_q} <= {i_drv_a, i_drv_b};
      o_pulses_a <= o_pulses_a + {15'h0000, i_drv_a & ~a_q};
      o_pulses_b <= o_pulses_b + {15'h0000, i_drv_b & ~b_q};
    end
  end
endmodule // dopwm_gate_drv

// file: test/dopwm_top_tb.sv
// self-checking bench for the dual output pwm top
`timescale 1ns/10ps
module dopwm_top_tb;
  reg         clk       = 1'b0;
  reg         arst_n    = 1'b0;
  reg  [15:0] period    = 16'h00C8;
  reg  [7:0]  deadtime  = 8'h00;
  reg  [7:0]  control   = 8'h00;
  reg         push_pull = 1'b0;
  reg         ext_sel   = 1'b0;
  reg  [15:0] ext_ramp  = 16'h0000;
  wire        drv_a;
  wire        drv_b;
  wire [15:0] ramp;
  wire        start;
  wire        steer;
  wire        inhibit;
  wire        blank_short;
  wire [15:0] on_cycles;
  wire [15:0] pulses_a;
  wire [15:0] pulses_b;
  integer     err_total       = 0;
  integer     samples_checked = 0;
  integer     cycles          = 0;
  always #12.5 clk = ~clk;
  // external sawtooth of 200 steps; the run limit is 20000 cycles
  always @(posedge clk)
  begin
    #1;
    ext_ramp = (ext_ramp == 16'h00C7) ? 16'h0000 : ext_ramp + 16'h0001;
    cycles = cycles + 1;
    if (cycles == 32'h0000_4E20)
    begin
      err_total = err_total + 1;
      summarize;
    end
  end
  dopwm_top #(.PERIOD_MAX(16'h012C)) dopwm_top_inst
  (
    .I_CLOCK(clk), .I_ARST_N(arst_n), .i_PERIOD(period),
    .i_DEADTIME(deadtime), .i_CONTROL(control), .i_PUSH_PULL(push_pull),
    .i_EXT_RAMP_SEL(ext_sel), .i_EXT_RAMP(ext_ramp),
    .o_DRIVE_OUTPUT_A(drv_a), .o_DRIVE_OUTPUT_B(drv_b), .o_RAMP(ramp),
    .o_PERIOD_START(start), .o_STEER(steer), .o_INHIBIT(inhibit),
    .o_BLANK_SHORT(blank_short), .o_ON_CYCLES(on_cycles)
  );
  dopwm_gate_drv dopwm_gate_drv_inst
  (
    .i_clk(clk), .i_arst_n(arst_n), .i_drv_a(drv_a), .i_drv_b(drv_b),
    .o_pulses_a(pulses_a), .o_pulses_b(pulses_b)
  );
  task check(input [15:0] got, input [15:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task summarize;
  begin
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // settings change only under reset, so every case starts clean
  task apply(input [15:0] p, input [7:0] dt, input [7:0] ct,
             input pp, input ext);
  begin
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    // dead time always driven; mode set only under reset
    {period, deadtime, control, push_pull, ext_sel} = {p, dt, ct, pp, ext};
    repeat (3) @(posedge clk);
    #1;
    check({drv_a, drv_b, steer, inhibit}, 16'h0001);
    check(ramp, 16'h0000);
    arst_n = 1'b1;
  end
  endtask
  task wait_start;
  begin
    @(posedge clk);
    #1;
    while (start !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
  end
  endtask
  task settle;
  begin
    repeat (20) @(posedge clk);
    #1;
  end
  endtask
  task sc_level(input [7:0] dt, input [7:0] ct, input [15:0] on, input sh);
  begin
    apply(16'h00C8, dt, ct, 1'b0, 1'b0);
    repeat (3) wait_start;
    settle;
    check(on_cycles, on);
    if (on != 16'h0000)
      check(blank_short, sh);
  end
  endtask
  task sc_modes;
  begin
    apply(16'h00C8, 8'h00, 8'h00, 1'b0, 1'b0);
    repeat (4) wait_start;
    check(pulses_a, 16'h0004);
    check(pulses_b, 16'h0004);
    apply(16'h00C8, 8'h00, 8'h00, 1'b1, 1'b0);
    repeat (4) wait_start;
    check(pulses_a, 16'h0002);
    check(pulses_b, 16'h0002);
  end
  endtask
  task sc_span(input [15:0] p, input [15:0] on);
    time    t0;
    integer n;
  begin
    apply(p, 8'h00, 8'h00, 1'b0, 1'b0);
    repeat (2) wait_start;
    t0 = $time;
    wait_start;
    n = ($time - t0) / 32'h0000_0019;
    check(n[15:0], p);
    settle;
    check(on_cycles, on);
  end
  endtask
  task sc_ext;
  begin
    apply(16'h00C8, 8'h00, 8'h00, 1'b1, 1'b1);
    repeat (3) wait_start;
    settle;
    check(on_cycles, 16'h00C2);
  end
  endtask
  initial
  begin
    sc_level(8'h00, 8'h00, 16'h00C2, 1'b1);
    // long dead time keeps blanking above the toggle minimum
    sc_level(8'h80, 8'h00, 16'h0061, 1'b0);
    sc_level(8'h00, 8'h80, 16'h0061, 1'b0);
    sc_level(8'h00, 8'hFF, 16'h0000, 1'b0);
    sc_level(8'hFF, 8'h00, 16'h0000, 1'b0);
    sc_modes;
    sc_span(16'h0086, 16'h0081);
    sc_span(16'h012C, 16'h0123);
    sc_ext;
    summarize;
  end
endmodule // dopwm_top_tb
